// >>> dv/regulator_fault_supervisor_bench.sv
`timescale 1ns/1ps
// Walks the supervisor through start-up, glitches and each fault kind.
module regulator_fault_supervisor_bench;
    import rfs_pkg::*;
    localparam rfs_sense_type S_NONE = 5'h00;
    localparam rfs_sense_type S_OC   = 5'h10;
    localparam rfs_sense_type S_SC   = 5'h08;
    localparam rfs_sense_type S_OV   = 5'h04;
    localparam rfs_sense_type S_REL  = 5'h02;
    localparam rfs_sense_type S_UV   = 5'h01;
    logic          sys_clk_i    = 1'b0;
    logic          resetn_i     = 1'b0;
    logic          enable_i     = 1'b0;
    logic          por_i        = 1'b0;
    logic          ce           = 1'b1;
    rfs_sense_type core_s       = S_NONE;
    rfs_sense_type nb_s         = S_NONE;
    logic          pg_data;
    logic          pg_oe;
    rfs_drive_type core_drv;
    rfs_drive_type nb_drv;
    logic          ss;
    logic          oc_f;
    logic          uv_f;
    logic          ov_f;
    logic          pg_line;
    logic          idle;
    int            failures     = 0;
    int            total_checks = 0;
    int            seed         = 32'hda752de6;
    int            len;
    rfs_sense_type pick;

    // Clock at 10 MHz.
    always #50 sys_clk_i = ~sys_clk_i;

    rfs_supervisor uut (
        .sys_clk_i           (sys_clk_i),
        .resetn_i            (resetn_i),
        .ce_i                (ce),
        .enable_i            (enable_i),
        .por_i               (por_i),
        .core_sense_i        (core_s),
        .nb_sense_i          (nb_s),
        .power_good_out_o    (pg_data),
        .power_good_out_oe_o (pg_oe),
        .core_drive_o        (core_drv),
        .nb_drive_o          (nb_drv),
        .soft_start_o        (ss),
        .oc_latched_o        (oc_f),
        .uv_latched_o        (uv_f),
        .ov_latched_o        (ov_f)
    );

    rfs_stage_model stage (
        .pg_data_i    (pg_data),
        .pg_oe_i      (pg_oe),
        .core_drive_i (core_drv),
        .nb_drive_i   (nb_drv),
        .pg_line_o    (pg_line),
        .stage_idle_o (idle)
    );

    // A held condition qualifies once it has lasted the full count.
    function automatic logic trips(input int held, input int limit);
        return held >= limit;
    endfunction

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Sampling on the falling edge keeps clear of the launch edge.
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    task automatic drive(input rfs_sense_type c, input rfs_sense_type n);
        @(posedge sys_clk_i);
        core_s <= c;
        nb_s   <= n;
    endtask

    task automatic wait_ss(input logic v, input int bound);
        int n;
        n = 0;
        while (ss !== v) begin
            if (n == bound) begin
                failures++;
                $display("wrong value at %0t: soft-start wait ran out", $time);
                test_done();
            end
            n++;
            cyc(1);
        end
    endtask

    // Toggles enable and follows the soft-start to a good output.
    task automatic restart;
        @(posedge sys_clk_i);
        enable_i <= 1'b0;
        cyc(5);
        check(pg_line === 1'b0, "power good high while disabled");
        @(posedge sys_clk_i);
        enable_i <= 1'b1;
        wait_ss(1'b1, 10);
        cyc(100);
        check(pg_line === 1'b0, "power good high in soft-start");
        wait_ss(1'b0, SS_CYC + 50);
        cyc(4);
        check(pg_line === 1'b1 && idle === 1'b0, "not running after soft-start");
    endtask

    // Main sequence; the fault scenarios reuse one restart path.
    initial begin
        repeat (10) @(posedge sys_clk_i);
        check(pg_line === 1'b0 && core_drv.all_off === 1'b1, "outputs live in reset");
        resetn_i <= 1'b1;
        restart();
        $display("test startup finished");
        // With the clock enable low the synchronisers are frozen, so a short pulse then is never seen.
        @(posedge sys_clk_i);
        ce     <= 1'b0;
        core_s <= S_SC;
        cyc(20);
        check(pg_line === 1'b1 && oc_f === 1'b0 && ss === 1'b0, "state moved with clock enable low");
        @(posedge sys_clk_i);
        ce     <= 1'b1;
        core_s <= S_NONE;
        cyc(6);
        check(oc_f === 1'b0 && pg_line === 1'b1, "frozen pulse acted on after clock enable");
        $display("test clock enable finished");
        // Excursions longer than half the count would sum past it if gaps were ignored.
        repeat (6) begin
            len  = OC_QUAL_CYC / 2 + ($unsigned($random(seed)) % (OC_QUAL_CYC / 2 - 10));
            pick = ($random(seed) & 1) ? S_UV : S_OC;
            if ($random(seed) & 1) drive(pick, S_NONE);
            else drive(S_NONE, pick);
            cyc(len);
            check(pg_line === 1'b0, "power good high during excursion");
            drive(S_NONE, S_NONE);
            cyc(6);
            check(oc_f === trips(len, OC_QUAL_CYC) && uv_f === 1'b0, "short excursion latched");
            check(pg_line === 1'b1, "power good not restored");
        end
        $display("test glitches finished");
        drive(S_OC, S_NONE);
        cyc(OC_QUAL_CYC - 5);
        check(oc_f === 1'b0, "overcurrent acted early");
        cyc(11);
        drive(S_NONE, S_NONE);
        cyc(4);
        check(oc_f === 1'b1 && uv_f === 1'b0, "overcurrent not latched alone");
        check(core_drv.tristate === 1'b1 && nb_drv.tristate === 1'b1, "drivers not tri-stated");
        cyc(200);
        check(ss === 1'b0 && pg_line === 1'b0 && idle === 1'b1, "regulators retried");
        restart();
        check(oc_f === 1'b0, "overcurrent flag kept");
        $display("test overcurrent finished");
        drive(S_NONE, S_UV);
        cyc(UV_QUAL_CYC - 5);
        check(uv_f === 1'b0, "undervoltage acted early");
        cyc(11);
        drive(S_NONE, S_NONE);
        cyc(4);
        check(uv_f === 1'b1 && oc_f === 1'b0, "undervoltage not latched alone");
        check(core_drv.all_off === 1'b1 && nb_drv.all_off === 1'b1 && pg_line === 1'b0, "drivers on");
        restart();
        $display("test undervoltage finished");
        drive(S_NONE, S_SC);
        cyc(5);
        check(oc_f === 1'b1 && nb_drv.tristate === 1'b1, "short circuit not immediate");
        drive(S_OV, S_NONE);
        cyc(5);
        check(core_drv.low_on === 1'b1 && nb_drv.low_on === 1'b0 && ov_f === 1'b1, "clamp wrong");
        drive(S_REL, S_NONE);
        cyc(5);
        check(core_drv.low_on === 1'b0 && core_drv.all_off === 1'b1, "clamp not released");
        drive(S_OV, S_OV);
        cyc(5);
        check(core_drv.low_on === 1'b1 && nb_drv.low_on === 1'b1 && pg_line === 1'b0, "clamp not repeated");
        drive(S_REL, S_REL);
        cyc(5);
        check(nb_drv.low_on === 1'b0 && nb_drv.all_off === 1'b1, "northbridge clamp not released");
        @(posedge sys_clk_i);
        enable_i <= 1'b0;
        cyc(5);
        @(posedge sys_clk_i);
        enable_i <= 1'b1;
        cyc(30);
        check(ss === 1'b0 && ov_f === 1'b1, "enable cleared overvoltage");
        @(posedge sys_clk_i);
        por_i <= 1'b1;
        cyc(5);
        check(pg_line === 1'b0, "power good high in power-on reset");
        @(posedge sys_clk_i);
        por_i <= 1'b0;
        drive(S_NONE, S_NONE);
        restart();
        check(ov_f === 1'b0, "overvoltage flag kept");
        $display("test overvoltage finished");
        test_done();
    end
endmodule

// >>> dv/rfs_stage_model.sv
`timescale 1ns/1ps
// Stands in for the power stage and the pulled-up power-good net.
module rfs_stage_model (
    input  wire logic                   pg_data_i,
    input  wire logic                   pg_oe_i,
    input  wire rfs_pkg::rfs_drive_type core_drive_i,
    input  wire rfs_pkg::rfs_drive_type nb_drive_i,
    output logic                        pg_line_o,
    output logic                        stage_idle_o
);
    import rfs_pkg::*;
    // The resistor pulls the net high whenever nobody sinks it.
    assign pg_line_o = pg_oe_i ? pg_data_i : 1'b1;
    // A stage is idle when it is neither switching nor clamped.
    assign stage_idle_o = (core_drive_i.tristate | core_drive_i.all_off)
                        & (nb_drive_i.tristate | nb_drive_i.all_off)
                        & ~core_drive_i.low_on & ~nb_drive_i.low_on;
endmodule

// >>> hw/rfs_qual_timer.sv
`timescale 1ns/1ps
// Counts how long a condition has held and flags once it reaches the limit.
module rfs_qual_timer #(
    parameter int unsigned LIMIT = 16
) (
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic ce_i,
    input  wire logic cond_i,
    output logic      expired_o
);
    import rfs_pkg::*;

    logic [QCNT_W-1:0] cnt_q;
    logic [QCNT_W-1:0] cnt_d;
    localparam logic [QCNT_W-1:0] LIM = QCNT_W'(LIMIT);

    // Restart whenever the condition drops out, saturate at the limit.
    always_comb begin
        if (!cond_i) begin
            cnt_d = '0;
        end else if (cnt_q != LIM) begin
            cnt_d = cnt_q + QCNT_W'(1);
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
        end else if (ce_i) begin
            cnt_q <= cnt_d;
        end
    end

    assign expired_o = cond_i && (cnt_q == LIM);

endmodule

// >>> hw/rfs_supervisor.sv
`timescale 1ns/1ps
// Fault supervisor and power-good logic for the core and northbridge regulators.
module rfs_supervisor (
    input  wire logic                  sys_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  ce_i,
    input  wire logic                  enable_i,
    input  wire logic                  por_i,
    input  wire rfs_pkg::rfs_sense_type core_sense_i,
    input  wire rfs_pkg::rfs_sense_type nb_sense_i,
    output logic                       power_good_out_o,
    output logic                       power_good_out_oe_o,
    output rfs_pkg::rfs_drive_type     core_drive_o,
    output rfs_pkg::rfs_drive_type     nb_drive_o,
    output logic                       soft_start_o,
    output logic                       oc_latched_o,
    output logic                       uv_latched_o,
    output logic                       ov_latched_o
);
    import rfs_pkg::*;

    // Two-stage synchronisers for every pin input; only stage two is read.
    localparam int unsigned NSYNC = 2 + 2 * 5;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    assign pin_raw = {enable_i, por_i, core_sense_i, nb_sense_i};

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else if (ce_i) begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
        end
    end

    logic          en_s;
    logic          por_s;
    rfs_sense_type sn [N_OUT];
    assign en_s          = s2_q[NSYNC-1];
    assign por_s         = s2_q[NSYNC-2];
    assign sn[CORE_IDX]  = s2_q[9:5];
    assign sn[NB_IDX]    = s2_q[4:0];

    // Core oc comparator is 5*Vc versus threshold/6 and the nb comparator
    // is the low-side drop versus the reference drop; both arrive as oc.
    logic [N_OUT-1:0] oc_raw;
    logic [N_OUT-1:0] sc_raw;
    logic [N_OUT-1:0] ov_raw;
    logic [N_OUT-1:0] rel_raw;
    logic [N_OUT-1:0] uv_raw;
    genvar gi;
    generate
        for (gi = 0; gi < N_OUT; gi++) begin : g_cmp
            assign oc_raw[gi]  = sn[gi].oc;
            assign sc_raw[gi]  = sn[gi].sc;
            assign ov_raw[gi]  = sn[gi].ov;
            assign rel_raw[gi] = sn[gi].ov_rel;
            assign uv_raw[gi]  = sn[gi].uv;
        end
    endgenerate

    // The overcurrent timer qualifies in soft-start and run, the undervoltage timer in run only.
    rfs_state_type st_q;
    rfs_state_type st_d;
    logic          active;
    logic          oc_qual;
    logic          uv_qual;
    assign active = (st_q == ST_SOFT) || (st_q == ST_RUN);

    rfs_qual_timer #(
        .LIMIT (OC_QUAL_CYC)
    ) u_oc_timer (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .cond_i    (active && (|oc_raw)),
        .expired_o (oc_qual)
    );

    rfs_qual_timer #(
        .LIMIT (UV_QUAL_CYC)
    ) u_uv_timer (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .cond_i    ((st_q == ST_RUN) && (|uv_raw)),
        .expired_o (uv_qual)
    );

    // Fault latches, enable toggle detection and the soft-start counter.
    logic             en_prev_q;
    logic             en_prev_d;
    logic             oc_lat_q;
    logic             oc_lat_d;
    logic             uv_lat_q;
    logic             uv_lat_d;
    logic             ov_lat_q;
    logic             ov_lat_d;
    logic [N_OUT-1:0] clamp_q;
    logic [N_OUT-1:0] clamp_d;
    logic [19:0]      ss_cnt_q;
    logic [19:0]      ss_cnt_d;
    logic             en_rise;
    logic             oc_trip;
    logic             enabled;
    localparam logic [19:0] SS_LAST = 20'(SS_CYC - 1);

    assign enabled = en_s && !por_s;
    assign en_rise = en_s && !en_prev_q;
    assign oc_trip = active && ((|sc_raw) || oc_qual);

    // One next-state process for the whole supervisor.
    always_comb begin
        st_d      = st_q;
        en_prev_d = en_s;
        oc_lat_d  = oc_lat_q;
        uv_lat_d  = uv_lat_q;
        ov_lat_d  = ov_lat_q;
        clamp_d   = clamp_q;
        ss_cnt_d  = ss_cnt_q;
        // Overvoltage clamp per output runs in every enabled state.
        for (int i = 0; i < N_OUT; i++) begin
            if (!enabled) begin
                clamp_d[i] = 1'b0;
            end else if (ov_raw[i]) begin
                clamp_d[i] = 1'b1;
            end else if (rel_raw[i]) begin
                clamp_d[i] = 1'b0;
            end
        end
        if (enabled && (|ov_raw)) begin
            ov_lat_d = 1'b1;
        end
        case (st_q)
            ST_OFF: begin
                ss_cnt_d = '0;
                if (enabled && !ov_lat_q) begin
                    st_d = ST_SOFT;
                end
            end
            ST_SOFT, ST_RUN: begin
                if (st_q == ST_SOFT) begin
                    ss_cnt_d = ss_cnt_q + 20'h00001;
                    if (ss_cnt_q == SS_LAST) begin
                        st_d = ST_RUN;
                    end
                end
                if (!enabled) begin
                    st_d = ST_OFF;
                end else if (|ov_raw) begin
                    st_d = ST_OVLCK;
                end else if (oc_trip) begin
                    oc_lat_d = 1'b1;
                    st_d     = ST_FAULT;
                end else if (uv_qual) begin
                    uv_lat_d = 1'b1;
                    st_d     = ST_FAULT;
                end
            end
            ST_FAULT: begin
                if (|ov_raw) begin
                    st_d = ST_OVLCK;
                end else if (en_rise) begin
                    oc_lat_d = 1'b0;
                    uv_lat_d = 1'b0;
                    ss_cnt_d = '0;
                    st_d     = ST_SOFT;
                end
            end
            ST_OVLCK: begin
                // Only a power-on reset or block reset leaves this state.
                st_d = ST_OVLCK;
            end
            default: begin
                st_d = ST_OFF;
            end
        endcase
        if (por_s) begin
            // Supply reset clears every latch, overvoltage included.
            st_d     = ST_OFF;
            oc_lat_d = 1'b0;
            uv_lat_d = 1'b0;
            ov_lat_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st_q      <= ST_OFF;
            en_prev_q <= 1'b0;
            oc_lat_q  <= 1'b0;
            uv_lat_q  <= 1'b0;
            ov_lat_q  <= 1'b0;
            clamp_q   <= '0;
            ss_cnt_q  <= '0;
        end else if (ce_i) begin
            st_q      <= st_d;
            en_prev_q <= en_prev_d;
            oc_lat_q  <= oc_lat_d;
            uv_lat_q  <= uv_lat_d;
            ov_lat_q  <= ov_lat_d;
            clamp_q   <= clamp_d;
            ss_cnt_q  <= ss_cnt_d;
        end
    end

    // Outputs: power-good released only in run, enabled, with no ov, oc or uv sense and no clamp.
    logic          pg_release;
    rfs_drive_type drv [N_OUT];
    assign pg_release = (st_q == ST_RUN) && enabled && !(|ov_raw)
                        && !(|oc_raw) && !(|uv_raw) && !(|clamp_q);
    assign power_good_out_o    = 1'b0;
    assign power_good_out_oe_o = !pg_release;

    generate
        for (gi = 0; gi < N_OUT; gi++) begin : g_drv
            always_comb begin
                drv[gi] = '0;
                if (clamp_q[gi]) begin
                    drv[gi].low_on = 1'b1;
                end else if ((st_q == ST_FAULT) && oc_lat_q) begin
                    drv[gi].tristate = 1'b1;
                end else if (!active) begin
                    drv[gi].all_off = 1'b1;
                end
            end
        end
    endgenerate

    assign core_drive_o  = drv[CORE_IDX];
    assign nb_drive_o    = drv[NB_IDX];
    assign soft_start_o  = (st_q == ST_SOFT);
    assign oc_latched_o  = oc_lat_q;
    assign uv_latched_o  = uv_lat_q;
    assign ov_latched_o  = ov_lat_q;

    // Assertions.
    ov_lock_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && st_q == ST_OVLCK && !por_s) |=> st_q == ST_OVLCK)
        else $error("overvoltage lock left without supply reset");
    pg_softstart_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st_q != ST_RUN |-> power_good_out_oe_o)
        else $error("power good released outside run");
    pg_disable_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!en_s || por_s) |-> power_good_out_oe_o)
        else $error("power good released while disabled");
    fault_latch_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && st_q == ST_FAULT && !en_rise && !(|ov_raw) && !por_s) |=> st_q == ST_FAULT)
        else $error("fault state left without enable toggle");
    sc_fast_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && st_q == ST_RUN && enabled && !(|ov_raw) && (|sc_raw)) |=> st_q == ST_FAULT && oc_lat_q)
        else $error("short circuit not acted on at once");
    oc_tristate_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (st_q == ST_FAULT && oc_lat_q && !(|clamp_q)) |-> core_drive_o.tristate && nb_drive_o.tristate)
        else $error("drivers not tri-stated after overcurrent");
    ov_clamp_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && enabled && ov_raw[CORE_IDX]) |=> core_drive_o.low_on)
        else $error("low side not clamped on overvoltage");
    ov_release_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && clamp_q[NB_IDX] && !ov_raw[NB_IDX] && rel_raw[NB_IDX]) |=> !nb_drive_o.low_on)
        else $error("clamp kept past release level");
    oc_short_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && st_q == ST_RUN && !(|sc_raw) && $rose(|oc_raw)) |=> !oc_lat_q)
        else $error("overcurrent acted on without qualification");

    softstart_c: cover property (@(posedge sys_clk_i) st_q == ST_SOFT ##1 st_q == ST_RUN);
    oc_fault_c:  cover property (@(posedge sys_clk_i) st_q == ST_RUN ##1 st_q == ST_FAULT && oc_lat_q);
    uv_fault_c:  cover property (@(posedge sys_clk_i) st_q == ST_RUN ##1 st_q == ST_FAULT && uv_lat_q);
    ov_lock_c:   cover property (@(posedge sys_clk_i) st_q == ST_OVLCK && |clamp_q);

endmodule

// >>> include/rfs_pkg.sv
// Functional notes
// - Power-good low through shutdown and soft-start.
// - Power-good low on any fault or disable.
// - Faults latch off; enable or reset restarts.
// - Overvoltage fault ignores enable toggle; reset only.
// - Core overcurrent: five times sense versus threshold/6.
// - Overcurrent acts only after 100 us persistence.
// - Short-circuit check at 2.25x trips immediately.
// - Northbridge overcurrent from low-side drop comparison.
// - Overcurrent shuts both regulators, tri-states, no retry.
// - Overvoltage faults at once, low-sides of offender on.
// - Low-sides on until release level, then off; repeat.
// - Overvoltage detection stays active while enabled.
// - Undervoltage for 205 us latches, drivers off.
// - Undervoltage is independent of overcurrent.
package rfs_pkg;

    localparam int unsigned CLK_FREQ_HZ  = 10_000_000;
    localparam int unsigned OC_QUAL_NS   = 100_000;
    localparam int unsigned UV_QUAL_NS   = 205_000;
    localparam int unsigned SS_TIME_NS   = 1_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
    // Least times round up to whole cycles.
    localparam int unsigned OC_QUAL_CYC  = (OC_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned UV_QUAL_CYC  = (UV_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SS_CYC       = (SS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned QCNT_W       = 12;
    localparam int unsigned N_OUT        = 2;
    localparam int unsigned CORE_IDX     = 0;
    localparam int unsigned NB_IDX       = 1;

    // Supervisor states, one-hot.
    typedef enum logic [4:0] {
        ST_OFF   = 5'h01,
        ST_SOFT  = 5'h02,
        ST_RUN   = 5'h04,
        ST_FAULT = 5'h08,
        ST_OVLCK = 5'h10
    } rfs_state_type;

    // Comparator results per output, synchronised inside the supervisor.
    typedef struct packed {
        logic oc;
        logic sc;
        logic ov;
        logic ov_rel;
        logic uv;
    } rfs_sense_type;

    // Gate-driver command per output.
    typedef struct packed {
        logic tristate;
        logic low_on;
        logic all_off;
    } rfs_drive_type;

endpackage
